// file: logic/csc_consts.vh
// constants for the clock synthesizer output control block
// assumes a single 200 MHz system clock
`ifndef CSC_CONSTS_VH
`define CSC_CONSTS_VH
`define CSC_ADDR_W        8
`define CSC_OFS_OUT_RATIO 8'h0c
`define CSC_OFS_FB_DIV    8'h0d
`define CSC_OFS_REF_DIV   8'h0e
`define CSC_RST_BYTE      8'h00
`define CSC_MASK_B12      8'h9f
`define CSC_MASK_B13      8'h7f
`define CSC_MASK_B14      8'h7f
`define CSC_B12_REF2_EN   7
`define CSC_B12_RATIO_HI  4
`define CSC_B12_RATIO_LO  2
`define CSC_B12_PCI_SEL   1
`define CSC_B12_HUB_SEL   0
`define CSC_B14_DIV_SRC   0
`define CSC_RATIO_STRAP   3'h0
`define CSC_RATIO_8       3'h2
`define CSC_RATIO_9       3'h3
`define CSC_RATIO_10      3'h4
`define CSC_RATIO_12A     3'h5
`define CSC_RATIO_12B     3'h7
`define CSC_DIV_8         5'h08
`define CSC_DIV_9         5'h09
`define CSC_DIV_10        5'h0a
`define CSC_DIV_12        5'h0c
`define CSC_DIV_NONE      5'h00
`define CSC_P_A           28'd127993333
`define CSC_P_B           28'd76796000
`define CSC_P_C           28'd95995000
`define CSC_P_D           28'd63996667
`define CSC_P_E           28'd191990000
`define CSC_SYNC_STAGES   2
`define CSC_RESTART_SLOTS 2
`define CSC_LAST_SLOT     2'd1
`define CSC_NUM_BYTES     3
`define CSC_BYTE_W        8
`define CSC_IDX_B12       0
`define CSC_IDX_B13       1
`define CSC_IDX_B14       2
`define CSC_SEL_NONE      3'h0
`define CSC_SEL_B12       3'h1
`define CSC_SEL_B13       3'h2
`define CSC_SEL_B14       3'h4
`define CSC_FB_HI         6
`define CSC_FB_LO         0
`define CSC_REF_HI        6
`define CSC_REF_LO        1
`endif

// file: logic/csc_clock_control.v
// control logic of the clock synthesizer: configuration bytes and stop sequencing
// assumes edge strobes from the clock domains, sync to i_clk_sys
//
// Behaviour
// - bit 7 enables third reference clock, reset off
// - ratio field selects vco to agp divider
// - agp kept at twice pci frequency
// - bit 0 selects strap or fractional source
// - bit 1 pci source, only when bit0 set
// - byte thirteen holds seven bit feedback divider
// - byte fourteen bits 6:1 reference divider
// - byte fourteen bit 0 selects rom or registers
// - divider change keeps other clock ratios
// - strap code picks pll constant, part one
// - strap code picks pll constant, part two
// - power down input synchronised, release after pll lock
// - clocks stop low, then pll powers down
// - cpu outputs float, others low in power down
// - outputs restart within two pci cycles
// - cpu stop after two complement clock edges
// - stopped cpu outputs three stated
// - cpu outputs restart within two cycles
// - pci stop keeps free running pci running
// - pci clocks resume within two pci periods
// - fractional aligner frequency has no spread
`timescale 1ns/1ps
`include "csc_consts.vh"
module csc_clock_control (
  input  wire        i_clk_sys,
  input  wire        i_rst,
  input  wire [7:0]  i_cfg_addr,
  input  wire [7:0]  i_cfg_wdata,
  input  wire        i_cfg_wr,
  input  wire        i_cfg_rd,
  input  wire [4:0]  i_frequency_strap_code,
  input  wire        i_power_down_n,
  input  wire        i_pll_locked,
  input  wire        i_cpu_clock_stop_n,
  input  wire        i_pci_clock_stop_n,
  input  wire        i_cpu_clock_complement_rise,
  input  wire        i_pci_rise,
  input  wire        i_cpu_stoppable,
  input  wire        i_free_running_pci_clock_free_run,
  output reg  [7:0]  o_cfg_rdata,
  output reg         o_ref2_en,
  output reg  [4:0]  o_agp_div,
  output reg  [4:0]  o_pci_div,
  output reg         o_hub_clock_fixed_source_select,
  output reg         o_pci_fixed_source_select,
  output reg         o_spread_allowed,
  output reg  [6:0]  o_feedback_div,
  output reg  [5:0]  o_reference_div,
  output reg         o_div_from_regs,
  output reg  [27:0] o_pll_constant,
  output reg         o_pll_power_en,
  output reg         o_cpu_out_en,
  output reg         o_cpu_oe,
  output reg         o_pci_run,
  output reg         o_free_running_pci_clock_run,
  output reg         o_other_run
);

  // ---------------------------------------------------------------
  // helper functions
  // ---------------------------------------------------------------
  function [4:0] ratio_div;
    input [2:0] code;
    begin
      case (code)
        `CSC_RATIO_8:   ratio_div = `CSC_DIV_8;
        `CSC_RATIO_9:   ratio_div = `CSC_DIV_9;
        `CSC_RATIO_10:  ratio_div = `CSC_DIV_10;
        `CSC_RATIO_12A: ratio_div = `CSC_DIV_12;
        `CSC_RATIO_12B: ratio_div = `CSC_DIV_12;
        default:        ratio_div = `CSC_DIV_NONE;
      endcase
    end
  endfunction

  function [27:0] pll_const;
    input [4:0] fs;
    begin
      case (fs)
        5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h1e:
          pll_const = `CSC_P_A;
        5'h06, 5'h07, 5'h10, 5'h11, 5'h12, 5'h13, 5'h14:
          pll_const = `CSC_P_B;
        5'h0e, 5'h0f, 5'h18:
          pll_const = `CSC_P_D;
        5'h1f:
          pll_const = `CSC_P_E;
        default:
          pll_const = `CSC_P_C;
      endcase
    end
  endfunction

  // ---------------------------------------------------------------
  // configuration bytes
  // ---------------------------------------------------------------
  function [`CSC_NUM_BYTES-1:0] cfg_onehot;
    input [7:0] addr;
    begin
      case (addr)
        `CSC_OFS_OUT_RATIO: cfg_onehot = `CSC_SEL_B12;
        `CSC_OFS_FB_DIV:    cfg_onehot = `CSC_SEL_B13;
        `CSC_OFS_REF_DIV:   cfg_onehot = `CSC_SEL_B14;
        default:            cfg_onehot = `CSC_SEL_NONE;
      endcase
    end
  endfunction

  function [7:0] cfg_mask;
    input integer idx;
    begin
      case (idx)
        `CSC_IDX_B12: cfg_mask = `CSC_MASK_B12;
        `CSC_IDX_B13: cfg_mask = `CSC_MASK_B13;
        default:      cfg_mask = `CSC_MASK_B14;
      endcase
    end
  endfunction

  wire [`CSC_NUM_BYTES-1:0]             cfg_sel = cfg_onehot(i_cfg_addr);
  wire [`CSC_NUM_BYTES*`CSC_BYTE_W-1:0] cfg_all;
  wire [7:0]                            b12_byte;
  wire [7:0]                            b13_byte;
  wire [7:0]                            b14_byte;

  genvar gi;
  generate
    for (gi = 0; gi < `CSC_NUM_BYTES; gi = gi + 1) begin : g_cfg
      reg [7:0] byte_reg;
      always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
          byte_reg <= `CSC_RST_BYTE;
        end else if (i_cfg_wr && cfg_sel[gi]) begin
          byte_reg <= i_cfg_wdata & cfg_mask(gi);
        end
      end
      assign cfg_all[gi*`CSC_BYTE_W +: `CSC_BYTE_W] = byte_reg;
    end
  endgenerate

  assign b12_byte = cfg_all[`CSC_IDX_B12*`CSC_BYTE_W +: `CSC_BYTE_W];
  assign b13_byte = cfg_all[`CSC_IDX_B13*`CSC_BYTE_W +: `CSC_BYTE_W];
  assign b14_byte = cfg_all[`CSC_IDX_B14*`CSC_BYTE_W +: `CSC_BYTE_W];

  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_cfg_rdata <= `CSC_RST_BYTE;
    end else if (i_cfg_rd) begin
      case (cfg_sel)
        `CSC_SEL_B12: o_cfg_rdata <= b12_byte;
        `CSC_SEL_B13: o_cfg_rdata <= b13_byte;
        `CSC_SEL_B14: o_cfg_rdata <= b14_byte;
        default:      o_cfg_rdata <= `CSC_RST_BYTE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // frequency selection outputs
  // ---------------------------------------------------------------
  wire [4:0] agp_div_next = ratio_div(b12_byte[`CSC_B12_RATIO_HI:`CSC_B12_RATIO_LO]);
  wire       hub_sel      = b12_byte[`CSC_B12_HUB_SEL];

  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_ref2_en                       <= 1'b0;
      o_agp_div                       <= `CSC_DIV_NONE;
      o_pci_div                       <= `CSC_DIV_NONE;
      o_hub_clock_fixed_source_select <= 1'b0;
      o_pci_fixed_source_select       <= 1'b0;
      o_spread_allowed                <= 1'b1;
    end else begin
      o_ref2_en                       <= b12_byte[`CSC_B12_REF2_EN];
      o_agp_div                       <= agp_div_next;
      o_pci_div                       <= {agp_div_next[3:0], 1'b0};
      o_hub_clock_fixed_source_select <= hub_sel;
      o_pci_fixed_source_select       <= hub_sel & b12_byte[`CSC_B12_PCI_SEL];
      o_spread_allowed                <= ~hub_sel;
    end
  end

  // ---------------------------------------------------------------
  // pll divider outputs
  // ---------------------------------------------------------------
  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_feedback_div  <= 7'h00;
      o_reference_div <= 6'h00;
      o_div_from_regs <= 1'b0;
      o_pll_constant  <= `CSC_P_A;
    end else begin
      o_feedback_div  <= b13_byte[`CSC_FB_HI:`CSC_FB_LO];
      o_reference_div <= b14_byte[`CSC_REF_HI:`CSC_REF_LO];
      o_div_from_regs <= b14_byte[`CSC_B14_DIV_SRC];
      o_pll_constant  <= pll_const(i_frequency_strap_code);
    end
  end

  // ---------------------------------------------------------------
  // power-down sequencing
  // ---------------------------------------------------------------
  reg [1:0] pd_sync_reg;
  reg       pd_active_reg;
  reg [1:0] up_cnt_reg;

  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      pd_sync_reg <= 2'b11;
    end else begin
      pd_sync_reg <= {pd_sync_reg[0], i_power_down_n};
    end
  end

  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      pd_active_reg <= 1'b0;
      up_cnt_reg    <= 2'd0;
    end else if (!pd_sync_reg[1]) begin
      pd_active_reg <= 1'b1;
      up_cnt_reg    <= 2'd0;
    end else if (pd_active_reg && i_pll_locked && i_pci_rise) begin
      if (up_cnt_reg == `CSC_LAST_SLOT) begin
        pd_active_reg <= 1'b0;
      end
      up_cnt_reg <= up_cnt_reg + 2'd1;
    end
  end

  // ---------------------------------------------------------------
  // cpu and pci stop sequencing
  // ---------------------------------------------------------------
  reg [1:0] cpu_cnt_reg;
  reg       cpu_stopped_reg;
  reg       pci_stopped_reg;

  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      cpu_cnt_reg     <= 2'd0;
      cpu_stopped_reg <= 1'b0;
    end else if (i_cpu_clock_complement_rise) begin
      if (!i_cpu_clock_stop_n && i_cpu_stoppable) begin
        if (cpu_cnt_reg == `CSC_LAST_SLOT) begin
          cpu_stopped_reg <= 1'b1;
        end else begin
          cpu_cnt_reg <= cpu_cnt_reg + 2'd1;
        end
      end else begin
        cpu_cnt_reg     <= 2'd0;
        cpu_stopped_reg <= 1'b0;
      end
    end
  end

  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      pci_stopped_reg <= 1'b0;
    end else if (i_pci_rise) begin
      pci_stopped_reg <= ~i_pci_clock_stop_n;
    end
  end

  // ---------------------------------------------------------------
  // run controls
  // ---------------------------------------------------------------
  function run_gate;
    input pd_active;
    input stopped;
    begin
      run_gate = ~pd_active & ~stopped;
    end
  endfunction

  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_cpu_out_en <= 1'b1;
      o_cpu_oe     <= 1'b1;
      o_pci_run    <= 1'b1;
      o_free_running_pci_clock_run   <= 1'b1;
      o_other_run  <= 1'b1;
    end else begin
      o_cpu_out_en <= run_gate(pd_active_reg, cpu_stopped_reg);
      o_cpu_oe     <= run_gate(pd_active_reg, cpu_stopped_reg);
      o_pci_run    <= run_gate(pd_active_reg, pci_stopped_reg);
      o_free_running_pci_clock_run   <= run_gate(pd_active_reg, pci_stopped_reg & ~i_free_running_pci_clock_free_run);
      o_other_run  <= run_gate(pd_active_reg, 1'b0);
    end
  end

  // ---------------------------------------------------------------
  // pll power
  // ---------------------------------------------------------------
  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_pll_power_en <= 1'b1;
    end else begin
      o_pll_power_en <= ~(pd_active_reg & ~pd_sync_reg[1] & ~o_other_run);
    end
  end

endmodule // csc_clock_control

// file: dv/csc_far.sv
// far side model: cpu and pci edge strobes, pll lock
`timescale 1ns/1ps
module csc_far (
  input  wire i_clk_sys,
  input  wire i_pll_power_en,
  output reg  o_cpu_clock_complement_rise = 1'b0,
  output reg  o_pci_rise = 1'b0,
  output reg  o_pll_locked = 1'b0
);
  reg [3:0] cnt_reg = 4'h0;
  reg [3:0] lock_reg = 4'h0;
  always @(posedge i_clk_sys) begin
    cnt_reg <= cnt_reg + 4'h1;
    o_cpu_clock_complement_rise <= cnt_reg[1:0] == 2'h3;
    o_pci_rise <= cnt_reg[2:0] == 3'h7;
    lock_reg <= i_pll_power_en ? lock_reg + {3'h0, ~&lock_reg} : 4'h0;
    o_pll_locked <= &lock_reg;
  end
endmodule // csc_far

// file: dv/csc_chk_asserts.sv
// checker on the control block ports, bound below
`timescale 1ns/1ps
module csc_chk (
  input wire        i_clk_sys,
  input wire        i_rst,
  input wire [7:0]  i_cfg_addr,
  input wire [7:0]  i_cfg_wdata,
  input wire        i_cfg_wr,
  input wire [4:0]  i_frequency_strap_code,
  input wire        i_power_down_n,
  input wire        o_ref2_en,
  input wire [4:0]  o_agp_div,
  input wire [4:0]  o_pci_div,
  input wire [6:0]  o_feedback_div,
  input wire [5:0]  o_reference_div,
  input wire        o_div_from_regs,
  input wire [27:0] o_pll_constant,
  input wire        o_pll_power_en,
  input wire        o_cpu_oe,
  input wire        o_other_run
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  wire wa = i_cfg_wr && i_cfg_addr == 8'h0c;
  wire wb = i_cfg_wr && i_cfg_addr == 8'h0d;
  wire wc = i_cfg_wr && i_cfg_addr == 8'h0e;
  a_ref2_write: assert property (wa |-> ##2 o_ref2_en == $past(i_cfg_wdata[7], 2))
    else $error("ref2");
  a_fb_write: assert property (wb |-> ##2 o_feedback_div == $past(i_cfg_wdata[6:0], 2))
    else $error("fb div");
  a_ref_write: assert property (wc |-> ##2 o_reference_div == $past(i_cfg_wdata[6:1], 2))
    else $error("ref div");
  a_div_src: assert property (wc |-> ##2 o_div_from_regs == $past(i_cfg_wdata[0], 2))
    else $error("div src");
  a_ratio_pair: assert property (o_pci_div == {o_agp_div[3:0], 1'b0})
    else $error("ratio");
  a_pd_low: assert property (!i_power_down_n [*4] |=> !o_other_run)
    else $error("pd low");
  a_pd_float: assert property (!i_power_down_n [*4] |=> !o_cpu_oe)
    else $error("pd float");
  a_pll_off: assert property (!i_power_down_n [*5] |=> !o_pll_power_en)
    else $error("pll off");
  a_strap_top: assert property ((i_frequency_strap_code == 5'h1f) [*2]
    |=> o_pll_constant == 28'd191990000)
    else $error("strap");
  c_wr: cover property (wc);
  c_pd: cover property (!i_power_down_n [*6]);
  c_top: cover property ((i_frequency_strap_code == 5'h1f) [*3]);
endmodule // csc_chk
bind csc_clock_control csc_chk u_chk (
  .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_cfg_addr(i_cfg_addr),
  .i_cfg_wdata(i_cfg_wdata), .i_cfg_wr(i_cfg_wr),
  .i_frequency_strap_code(i_frequency_strap_code), .i_power_down_n(i_power_down_n),
  .o_ref2_en(o_ref2_en), .o_agp_div(o_agp_div), .o_pci_div(o_pci_div),
  .o_feedback_div(o_feedback_div), .o_reference_div(o_reference_div),
  .o_div_from_regs(o_div_from_regs), .o_pll_constant(o_pll_constant),
  .o_pll_power_en(o_pll_power_en), .o_cpu_oe(o_cpu_oe), .o_other_run(o_other_run));

// file: dv/tb.sv
// bench for the clock control block, far model csc_far
`timescale 1ns/1ps
`define E @(posedge i_clk_sys)
`define CHK(a,b) begin check_count++; if ((a)!==(b)) begin fail_count++; $display("mismatch %0t %h %h",$time,a,b); end end
module tb;
  reg i_clk_sys=0, i_rst=1, i_cfg_wr=0, i_cfg_rd=0, i_power_down_n=1;
  reg i_cpu_clock_stop_n=1, i_pci_clock_stop_n=1, i_cpu_stoppable=1, i_free_running_pci_clock_free_run=1;
  reg [7:0] i_cfg_addr=0, i_cfg_wdata=0;
  reg [4:0] i_frequency_strap_code=0;
  wire i_cpu_clock_complement_rise, i_pci_rise, i_pll_locked, o_ref2_en, o_spread_allowed, o_div_from_regs;
  wire o_hub_clock_fixed_source_select, o_pci_fixed_source_select, o_pll_power_en;
  wire o_cpu_out_en, o_cpu_oe, o_pci_run, o_free_running_pci_clock_run, o_other_run;
  wire [7:0] o_cfg_rdata;
  wire [4:0] o_agp_div, o_pci_div;
  wire [6:0] o_feedback_div;
  wire [5:0] o_reference_div;
  wire [27:0] o_pll_constant;
  int fail_count=0, check_count=0, seed=32'h6815a78c, k;
  int mb[3]='{0,0,0};
  int rt[8]='{0,0,8,9,10,12,0,12};
  always #2.5 i_clk_sys=~i_clk_sys;
  csc_clock_control dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_cfg_addr(i_cfg_addr),
    .i_cfg_wdata(i_cfg_wdata), .i_cfg_wr(i_cfg_wr), .i_cfg_rd(i_cfg_rd),
    .i_frequency_strap_code(i_frequency_strap_code), .i_power_down_n(i_power_down_n),
    .i_pll_locked(i_pll_locked), .i_cpu_clock_stop_n(i_cpu_clock_stop_n),
    .i_pci_clock_stop_n(i_pci_clock_stop_n), .i_cpu_clock_complement_rise(i_cpu_clock_complement_rise),
    .i_pci_rise(i_pci_rise), .i_cpu_stoppable(i_cpu_stoppable),
    .i_free_running_pci_clock_free_run(i_free_running_pci_clock_free_run), .o_cfg_rdata(o_cfg_rdata), .o_ref2_en(o_ref2_en),
    .o_agp_div(o_agp_div), .o_pci_div(o_pci_div),
    .o_hub_clock_fixed_source_select(o_hub_clock_fixed_source_select),
    .o_pci_fixed_source_select(o_pci_fixed_source_select),
    .o_spread_allowed(o_spread_allowed), .o_feedback_div(o_feedback_div),
    .o_reference_div(o_reference_div), .o_div_from_regs(o_div_from_regs),
    .o_pll_constant(o_pll_constant), .o_pll_power_en(o_pll_power_en),
    .o_cpu_out_en(o_cpu_out_en), .o_cpu_oe(o_cpu_oe), .o_pci_run(o_pci_run),
    .o_free_running_pci_clock_run(o_free_running_pci_clock_run), .o_other_run(o_other_run));
  csc_far far (.i_clk_sys(i_clk_sys), .i_pll_power_en(o_pll_power_en),
    .o_cpu_clock_complement_rise(i_cpu_clock_complement_rise), .o_pci_rise(i_pci_rise), .o_pll_locked(i_pll_locked));
  function int pexp(input int s);
    if (s<=5 || s==30) return 127993333;
    if (s==6 || s==7 || (s>=16 && s<=20)) return 76796000;
    if (s==14 || s==15 || s==24) return 63996667;
    if (s==31) return 191990000;
    return 95995000;
  endfunction
  task results;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count==0 && check_count>0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task wrb(input int a, input int d);
    `E i_cfg_addr<=a; i_cfg_wdata<=d; i_cfg_wr<=1;
    `E i_cfg_wr<=0;
    if (a>11 && a<15) mb[a-12]=d&(a==12?8'h9f:8'h7f);
  endtask
  task rdc(input int a);
    `E i_cfg_addr<=a; i_cfg_rd<=1;
    `E i_cfg_rd<=0;
    `E #1;
    `CHK(o_cfg_rdata,(a>11&&a<15)?mb[a-12]:0)
  endtask
  task pw(input bit p, input int n);
    k=0;
    for (int i=0; i<99 && k<n; i++) begin
      `E k+=p?i_pci_rise:i_cpu_clock_complement_rise;
    end
    if (k<n) begin
      fail_count++;
      $display("mismatch %0t no pulse", $time);
      results;
    end
    repeat(2) `E;
    #1;
  endtask
  initial begin
    repeat(3) `E;
    i_rst<=0;
    for (int a=12; a<16; a++) rdc(a);
    `CHK(o_spread_allowed,1'b1)
    repeat(6) begin
      wrb(13,$random(seed));
      wrb(14,$random(seed));
      wrb(12,$random(seed));
      wrb(15,$random(seed));
      for (int a=12; a<16; a++) rdc(a);
      `CHK(o_ref2_en,mb[0][7])
      `CHK(o_hub_clock_fixed_source_select,mb[0][0])
      `CHK(o_pci_fixed_source_select,mb[0][1]&mb[0][0])
      `CHK(o_spread_allowed,!mb[0][0])
      `CHK(o_feedback_div,mb[1][6:0])
      `CHK(o_reference_div,mb[2][6:1])
      `CHK(o_div_from_regs,mb[2][0])
    end
    foreach (rt[c]) if (c!=1 && c!=6) begin
      wrb(12,c<<2);
      repeat(2) `E;
      #1;
      `CHK(o_agp_div,rt[c][4:0])
      `CHK(o_pci_div,{rt[c][3:0],1'b0})
    end
    for (int s=0; s<32; s++) begin
      `E i_frequency_strap_code<=s[4:0];
      repeat(3) `E;
      #1;
      `CHK(o_pll_constant,pexp(s))
    end
    `E i_cpu_clock_stop_n<=0;
    pw(0,2);
    `CHK(o_cpu_oe,1'b0)
    `CHK(o_cpu_out_en,1'b0)
    `E i_cpu_clock_stop_n<=1;
    pw(0,1);
    `CHK(o_cpu_oe,1'b1)
    `E i_cpu_stoppable<=0; i_cpu_clock_stop_n<=0;
    pw(0,3);
    `CHK(o_cpu_oe,1'b1)
    `E i_cpu_stoppable<=1; i_cpu_clock_stop_n<=1;
    `E i_pci_clock_stop_n<=0;
    pw(1,1);
    `CHK(o_pci_run,1'b0)
    `CHK(o_free_running_pci_clock_run,1'b1)
    `E i_free_running_pci_clock_free_run<=0;
    pw(1,1);
    `CHK(o_free_running_pci_clock_run,1'b0)
    `E i_pci_clock_stop_n<=1;
    pw(1,2);
    `CHK(o_free_running_pci_clock_run,1'b1)
    `E i_power_down_n<=0;
    repeat(8) `E;
    #1;
    `CHK(o_other_run,1'b0)
    `CHK(o_pci_run,1'b0)
    `CHK(o_cpu_oe,1'b0)
    `CHK(o_pll_power_en,1'b0)
    `E i_power_down_n<=1;
    for (int i=0; i<99 && i_pll_locked!==1; i++) `E;
    `CHK(i_pll_locked,1'b1)
    if (i_pll_locked!==1) results;
    pw(1,2);
    `CHK(o_other_run&o_cpu_oe&o_pci_run,1'b1)
    results;
  end
endmodule // tb
